// ---- pkg/tmoc_pkg.sv ----
// Constants and types for the timer output and counter-clear control block.
// Assumes a single 200 MHz clock; the counter and comparators are outside.

package tmoc_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam int         ADDR_W      = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [7:0]  CTRL_RST    = 8'h00;

  // ********************************************************************
  // control field positions
  // ********************************************************************
  localparam int POS_MODE_HI   = 7;
  localparam int POS_MODE_LO   = 6;
  localparam int POS_ACT_HI    = 5;
  localparam int POS_ACT_LO    = 4;
  localparam int POS_LEVEL     = 3;
  localparam int POS_INVERT    = 2;
  localparam int POS_SWAP      = 1;
  localparam int POS_CLEAR_SEL = 0;

  // ********************************************************************
  // status field positions
  // ********************************************************************
  localparam int POS_ST_LEVEL  = 0;
  localparam int POS_ST_PIN    = 1;
  localparam int POS_ST_RUN    = 2;
  localparam int POS_ST_DRIVE  = 3;
  localparam int POS_ST_PULSE  = 4;

  localparam int NUM_PINS = 2;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    TMOC_MODE_COMPARE,
    TMOC_MODE_CAPTURE,
    TMOC_MODE_PWM,
    TMOC_MODE_TIMER
  } tmoc_mode_t;

  typedef enum logic [1:0] {
    TMOC_ACT_00,
    TMOC_ACT_01,
    TMOC_ACT_10,
    TMOC_ACT_11
  } tmoc_action_t;

  typedef struct packed {
    tmoc_mode_t   mode;
    tmoc_action_t action;
    logic         out_level_sel;
    logic         out_invert;
    logic         period_duty_swap;
    logic         clear_source_sel;
  } tmoc_ctrl_t;

  typedef struct packed {
    logic match_a;
    logic match_p;
    logic overflow;
  } tmoc_evt_t;

endpackage

// ---- verilog/tmoc_level_gen.sv ----
// Output level generator: the pin level before polarity inversion.
// Assumes match pulses and the run bit come from logic on the same clock.

module tmoc_level_gen (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // configuration
  input  wire tmoc_pkg::tmoc_ctrl_t ctrl,
  // timer events
  input  wire logic                 run_rise,
  input  wire logic                 match_a,
  input  wire logic                 duty_match,
  input  wire logic                 period_start,
  // result
  output logic                      level,
  output logic                      pulse_busy
);

  logic cmp_level_r;
  logic cmp_level_nxt;
  logic pwm_on_r;
  logic pwm_on_nxt;
  logic sp_on_r;
  logic sp_on_nxt;
  logic active;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    cmp_level_nxt = cmp_level_r;
    pwm_on_nxt    = pwm_on_r;
    sp_on_nxt     = sp_on_r;
    // restart returns the pin to its initial level
    if (run_rise) begin
      cmp_level_nxt = ctrl.out_level_sel;
    end else if (match_a) begin
      // driving the level the pin already has is no visible change
      case (ctrl.action)
        tmoc_pkg::TMOC_ACT_00: cmp_level_nxt = cmp_level_r;
        tmoc_pkg::TMOC_ACT_01: cmp_level_nxt = 1'b0;
        tmoc_pkg::TMOC_ACT_10: cmp_level_nxt = 1'b1;
        default:               cmp_level_nxt = ~cmp_level_r;
      endcase
    end
    // the pwm waveform keeps running even while forced, so a switch back is glitch free
    if (period_start) begin
      pwm_on_nxt = 1'b1;
    end else if (duty_match) begin
      pwm_on_nxt = 1'b0;
    end
    if (run_rise) begin
      sp_on_nxt = 1'b1;
    end else if (duty_match) begin
      sp_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_level_r <= 1'b0;
      pwm_on_r    <= 1'b0;
      sp_on_r     <= 1'b0;
    end else begin
      cmp_level_r <= cmp_level_nxt;
      pwm_on_r    <= pwm_on_nxt;
      sp_on_r     <= sp_on_nxt;
    end
  end

  // ********************************************************************
  // level selection
  // ********************************************************************
  always_comb begin
    case (ctrl.action)
      tmoc_pkg::TMOC_ACT_00: active = 1'b0;
      tmoc_pkg::TMOC_ACT_01: active = 1'b1;
      tmoc_pkg::TMOC_ACT_10: active = pwm_on_r;
      default:               active = sp_on_r;
    endcase
    if (ctrl.mode == tmoc_pkg::TMOC_MODE_PWM) begin
      level = ctrl.out_level_sel ? active : ~active;
    end else begin
      level = cmp_level_r;
    end
    pulse_busy = sp_on_r;
  end

endmodule

// ---- verilog/tmoc_top.sv ----
// Timer output and counter-clear control with an APB control register.
// Assumes the counter, comparators and run bit sit on the same pclk domain.
//
// The APB register port and the register offsets were decided locally.

module tmoc_top (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tmoc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // timer core events
  input  wire tmoc_pkg::tmoc_evt_t       evt,
  input  wire logic                      compare_p_zero,
  input  wire logic                      timer_run_enable,
  // timer core control
  output logic                           counter_clear,
  output logic                           period_from_a,
  // output pins
  output logic                           timer_out_pin_a,
  output logic                           timer_out_pin_b,
  output logic                           timer_out_pin_a_oe_n,
  output logic                           timer_out_pin_b_oe_n
);

  // ********************************************************************
  // state
  // ********************************************************************
  tmoc_pkg::tmoc_ctrl_t ctrl_r;
  tmoc_pkg::tmoc_ctrl_t ctrl_nxt;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 pready_r;
  logic                 pready_nxt;
  logic                 pslverr_r;
  logic                 pslverr_nxt;
  logic                 run_d_r;
  logic                 clear_r;
  logic                 clear_nxt;
  logic                 period_a_r;
  logic                 period_a_nxt;
  logic [tmoc_pkg::NUM_PINS-1:0] pin_r;
  logic [tmoc_pkg::NUM_PINS-1:0] pin_nxt;
  logic [tmoc_pkg::NUM_PINS-1:0] oe_n_r;
  logic [tmoc_pkg::NUM_PINS-1:0] oe_n_nxt;

  logic run_rise;
  logic duty_match;
  logic period_match;
  logic level;
  logic pulse_busy;
  logic drives;
  logic pin_level;
  logic access;
  logic hit_ctrl;
  logic hit_status;

  // ********************************************************************
  // apb slave
  // ********************************************************************
  // one wait state: pready is raised in the second access cycle so that
  // every answer comes from a flop, at the cost of one extra cycle
  assign access     = psel && penable;
  assign hit_ctrl   = (paddr == tmoc_pkg::ADDR_CTRL);
  assign hit_status = (paddr == tmoc_pkg::ADDR_STATUS);

  always_comb begin
    ctrl_nxt    = ctrl_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (access && !pready_r) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (hit_ctrl) begin
        prdata_nxt[7:0] = ctrl_r;
      end else if (hit_status) begin
        prdata_nxt[tmoc_pkg::POS_ST_LEVEL] = level;
        prdata_nxt[tmoc_pkg::POS_ST_PIN]   = pin_r[0];
        prdata_nxt[tmoc_pkg::POS_ST_RUN]   = run_d_r;
        prdata_nxt[tmoc_pkg::POS_ST_DRIVE] = ~oe_n_r[0];
        prdata_nxt[tmoc_pkg::POS_ST_PULSE] = pulse_busy;
        pslverr_nxt = pwrite;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // the write lands only at the edge where the master sees pready
    if (access && pready_r && pwrite && hit_ctrl) begin
      ctrl_nxt = tmoc_pkg::tmoc_ctrl_t'(pwdata[7:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= tmoc_pkg::tmoc_ctrl_t'(tmoc_pkg::CTRL_RST);
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ********************************************************************
  // run edge and period/duty roles
  // ********************************************************************
  assign run_rise = timer_run_enable && !run_d_r;

  always_comb begin
    if (ctrl_r.period_duty_swap) begin
      period_match = evt.match_a;
      duty_match   = evt.match_p;
    end else begin
      period_match = evt.match_p;
      duty_match   = evt.match_a;
    end
  end

  // ********************************************************************
  // counter clear
  // ********************************************************************
  always_comb begin
    clear_nxt    = 1'b0;
    period_a_nxt = 1'b0;
    case (ctrl_r.mode)
      tmoc_pkg::TMOC_MODE_COMPARE, tmoc_pkg::TMOC_MODE_TIMER: begin
        if (ctrl_r.clear_source_sel) begin
          clear_nxt = evt.match_a;
        end else begin
          clear_nxt = evt.match_p || (evt.overflow && compare_p_zero);
        end
        period_a_nxt = ctrl_r.clear_source_sel;
      end
      tmoc_pkg::TMOC_MODE_PWM: begin
        // clear-select plays no part here; the swap bit picks the period
        clear_nxt    = period_match;
        period_a_nxt = ctrl_r.period_duty_swap;
      end
      default: begin
        clear_nxt    = 1'b0;
        period_a_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d_r    <= 1'b0;
      clear_r    <= 1'b0;
      period_a_r <= 1'b0;
    end else begin
      run_d_r    <= timer_run_enable;
      clear_r    <= clear_nxt;
      period_a_r <= period_a_nxt;
    end
  end

  assign counter_clear = clear_r;
  assign period_from_a = period_a_r;

  // ********************************************************************
  // output level
  // ********************************************************************
  tmoc_level_gen u_level (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctrl         (ctrl_r),
    .run_rise     (run_rise),
    .match_a      (evt.match_a),
    .duty_match   (duty_match),
    .period_start (clear_r && (ctrl_r.mode == tmoc_pkg::TMOC_MODE_PWM)),
    .level        (level),
    .pulse_busy   (pulse_busy)
  );

  // ********************************************************************
  // pin drivers
  // ********************************************************************
  // capture and timer/counter modes release the pins to other functions
  assign drives    = (ctrl_r.mode == tmoc_pkg::TMOC_MODE_COMPARE) ||
                     (ctrl_r.mode == tmoc_pkg::TMOC_MODE_PWM);
  assign pin_level = drives ? (level ^ ctrl_r.out_invert) : 1'b0;

  generate
    for (genvar i = 0; i < tmoc_pkg::NUM_PINS; i++) begin : g_pin
      always_comb begin
        pin_nxt[i]  = pin_level;
        oe_n_nxt[i] = ~drives;
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_r[i]  <= 1'b0;
          oe_n_r[i] <= 1'b1;
        end else begin
          pin_r[i]  <= pin_nxt[i];
          oe_n_r[i] <= oe_n_nxt[i];
        end
      end
    end
  endgenerate

  assign timer_out_pin_a      = pin_r[0];
  assign timer_out_pin_b      = pin_r[1];
  assign timer_out_pin_a_oe_n = oe_n_r[0];
  assign timer_out_pin_b_oe_n = oe_n_r[1];

endmodule

// ---- tb/tmoc_props.sv ----
// Concurrent checks on the timer output and counter-clear control block.
// Assumes it is bound to tmoc_top and mirrors the control register from APB.

module tmoc_props (
  // clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  // apb
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [tmoc_pkg::ADDR_W-1:0]   paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic                          pready,
  // timer core
  input wire tmoc_pkg::tmoc_evt_t           evt,
  input wire logic                          compare_p_zero,
  input wire logic                          timer_run_enable,
  input wire logic                          counter_clear,
  input wire logic                          period_from_a,
  // pins
  input wire logic                          timer_out_pin_a,
  input wire logic                          timer_out_pin_a_oe_n,
  input wire logic                          timer_out_pin_b_oe_n
);
  // ******************************************************************
  // control mirror
  // ******************************************************************
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic       cmp;
  logic       cap;
  logic       pwm;
  logic       tmr;

  always_comb begin
    sh_nxt = sh_r;
    if (psel && penable && pready && pwrite && paddr == tmoc_pkg::ADDR_CTRL) begin
      sh_nxt = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= tmoc_pkg::CTRL_RST;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  assign cmp = (sh_r[7:6] == 2'h0);
  assign cap = (sh_r[7:6] == 2'h1);
  assign pwm = (sh_r[7:6] == 2'h2);
  assign tmr = (sh_r[7:6] == 2'h3);

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  clear_on_a_a: assert property ((cmp || tmr) && sh_r[0] && evt.match_a |=> counter_clear)
    else $error("no counter clear on match a");
  clear_on_p_a: assert property ((cmp || tmr) && !sh_r[0] && evt.match_p |=> counter_clear)
    else $error("no counter clear on match p");
  ovf_clear_a: assert property ((cmp || tmr) && !sh_r[0] && evt.overflow && compare_p_zero |=> counter_clear)
    else $error("no counter clear on overflow");
  ovf_block_a: assert property ((cmp || tmr) && !sh_r[0] && evt == 3'h1 && !compare_p_zero |=> !counter_clear)
    else $error("overflow cleared with nonzero period");
  pwm_clear_a: assert property (pwm && (sh_r[1] ? evt.match_a : evt.match_p) |=> counter_clear)
    else $error("no counter clear on pwm period match");
  capture_clear_a: assert property (cap |=> !counter_clear)
    else $error("counter clear in capture mode");
  period_swap_a: assert property (pwm && $stable(sh_r) |-> period_from_a == sh_r[1])
    else $error("period source does not follow swap bit");
  pin_release_a: assert property ((cap || tmr) && $stable(sh_r) && $past(presetn)
    |-> timer_out_pin_a_oe_n && timer_out_pin_b_oe_n)
    else $error("pins driven while released");
  pin_drive_a: assert property ((cmp || pwm) && $stable(sh_r) && $past(presetn)
    |-> !timer_out_pin_a_oe_n && !timer_out_pin_b_oe_n)
    else $error("pins not driven");
  run_restore_a: assert property (cmp && $rose(timer_run_enable) ##1 $stable(sh_r) && !evt.match_a
    |=> timer_out_pin_a == (sh_r[3] ^ sh_r[2]))
    else $error("run rise did not restore initial level");
  act_high_a: assert property (cmp && sh_r[5:4] == 2'h2 && evt.match_a && !$rose(timer_run_enable)
    ##1 $stable(sh_r) |=> timer_out_pin_a == !sh_r[2])
    else $error("match a did not drive high");
  act_low_a: assert property (cmp && sh_r[5:4] == 2'h1 && evt.match_a && !$rose(timer_run_enable)
    ##1 $stable(sh_r) |=> timer_out_pin_a == sh_r[2])
    else $error("match a did not drive low");

  run_rise_c: cover property (cmp && $rose(timer_run_enable));
  pwm_period_c: cover property (pwm && evt.match_p);
  clear_c: cover property (counter_clear);
endmodule

bind tmoc_top tmoc_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .evt(evt), .compare_p_zero(compare_p_zero),
  .timer_run_enable(timer_run_enable), .counter_clear(counter_clear), .period_from_a(period_from_a),
  .timer_out_pin_a(timer_out_pin_a), .timer_out_pin_a_oe_n(timer_out_pin_a_oe_n),
  .timer_out_pin_b_oe_n(timer_out_pin_b_oe_n)
);

// ---- tb/tmoc_pin_load.sv ----
// Load on the two timer output pins: resolves the level seen on each wire.
// Assumes no pull resistor, so a released wire shows the inverse of its last level.

module tmoc_pin_load (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pins from the block
  input  wire logic pin_a,
  input  wire logic pin_b,
  input  wire logic oe_a_n,
  input  wire logic oe_b_n,
  // wire levels
  output logic      wire_a,
  output logic      wire_b
);
  logic last_a_r;
  logic last_b_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_a_r <= 1'b0;
      last_b_r <= 1'b0;
    end else begin
      last_a_r <= oe_a_n ? last_a_r : pin_a;
      last_b_r <= oe_b_n ? last_b_r : pin_b;
    end
  end

  // a released line must not look like a held level
  assign wire_a = oe_a_n ? ~last_a_r : pin_a;
  assign wire_b = oe_b_n ? ~last_b_r : pin_b;
endmodule

// ---- tb/timer_output_and_clear_control_bench.sv ----
// Self-checking bench for the timer output and counter-clear control block.
// Assumes tmoc_top, tmoc_props (bound) and tmoc_pin_load are compiled before it.

module timer_output_and_clear_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pz, run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic        clr, pfa, pa, pb, oa, ob, wa, wb, err, cur;
  logic [7:0]  c;
  tmoc_pkg::tmoc_evt_t evt, e;
  int          fails, n_checks, k, rv;

  tmoc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .compare_p_zero(pz), .timer_run_enable(run), .counter_clear(clr), .period_from_a(pfa),
    .timer_out_pin_a(pa), .timer_out_pin_b(pb), .timer_out_pin_a_oe_n(oa), .timer_out_pin_b_oe_n(ob));
  tmoc_pin_load load (.pclk(pclk), .presetn(presetn), .pin_a(pa), .pin_b(pb), .oe_a_n(oa),
    .oe_b_n(ob), .wire_a(wa), .wire_b(wb));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ******************************************************************
  // tasks and expectations
  // ******************************************************************
  task close_out;
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk1(input logic g, input logic x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task chk32(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  // pready is sampled at the rising edge, the same edge at which the write lands
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fails++;
      close_out;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task setc(input logic [7:0] v);
    apb(1'b1, tmoc_pkg::ADDR_CTRL, {24'h0, v});
  endtask

  task pulse(input tmoc_pkg::tmoc_evt_t ev, input logic z);
    @(posedge pclk);
    evt <= ev; pz <= z;
    @(posedge pclk);
    evt <= 3'h0;
  endtask

  task settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  function automatic logic exp_clr(input logic [7:0] cv, input tmoc_pkg::tmoc_evt_t ev, input logic z);
    case (cv[7:6])
      2'h1: return 1'b0;
      2'h2: return cv[1] ? ev.match_a : ev.match_p;
      default: return cv[0] ? ev.match_a : (ev.match_p | (ev.overflow & z));
    endcase
  endfunction

  function automatic logic exp_lvl(input logic [1:0] act, input logic lv);
    case (act)
      2'h0: return lv;
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      default: return ~lv;
    endcase
  endfunction

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    {psel, penable, pwrite, run, pz} = 5'h0;
    paddr = 12'h000; pwdata = 32'h0; evt = 3'h0; presetn = 1'b0; fails = 0; n_checks = 0;
    rv = $urandom(32'hB1D8);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tmoc_pkg::ADDR_CTRL, 32'h0);
    chk32(rd, {24'h0, tmoc_pkg::CTRL_RST});
    // after reset: compare mode, level 0, pins driven, run low, no pulse
    apb(1'b0, tmoc_pkg::ADDR_STATUS, 32'h0);
    chk1(err, 1'b0);
    chk32(rd, 32'h1 << tmoc_pkg::POS_ST_DRIVE);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    chk1(err, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk1(err, 1'b1);
    chk32(rd, 32'h0);
    apb(1'b1, tmoc_pkg::ADDR_STATUS, 32'h1F);
    chk1(err, 1'b1);
    d = $urandom;
    apb(1'b1, tmoc_pkg::ADDR_CTRL, d);
    apb(1'b0, tmoc_pkg::ADDR_CTRL, 32'h0);
    chk32(rd, {24'h0, d[7:0]});
    for (k = 0; k < 16; k++) begin
      setc({2'h0, k[3:2], k[1], k[0], 2'h0});
      @(posedge pclk) run <= 1'b0;
      @(posedge pclk) run <= 1'b1;
      settle;
      chk1(wa, k[1] ^ k[0]);
      cur = k[1];
      repeat (2) begin
        pulse(3'h4, 1'b0);
        settle;
        cur = exp_lvl(k[3:2], cur);
        chk1(wa, cur ^ k[0]);
        chk1(wb, cur ^ k[0]);
      end
    end
    for (k = 0; k < 4; k++) begin
      setc({k[1:0], 6'h00});
      settle;
      chk1(oa, k[0]);
      chk1(ob, k[0]);
    end
    for (k = 0; k < 8; k++) begin
      setc({2'h2, 1'b0, k[2], k[0], k[1], 2'h0});
      settle;
      chk1(wa, (k[2] ? k[0] : ~k[0]) ^ k[1]);
    end
    for (k = 0; k < 2; k++) begin
      setc({2'h2, 2'h2, 1'b1, 1'b0, k[0], 1'b0});
      pulse(k[0] ? 3'h4 : 3'h2, 1'b0);
      settle;
      chk1(wa, 1'b1);
      pulse(k[0] ? 3'h2 : 3'h4, 1'b0);
      settle;
      chk1(wa, 1'b0);
      chk1(pfa, k[0]);
    end
    for (k = 0; k < 64; k++) begin
      c = (k < 2) ? 8'h00 : 8'($urandom);
      e = (k < 2) ? 3'h1 : 3'($urandom);
      cur = (k < 2) ? k[0] : 1'($urandom);
      setc(c);
      pulse(e, cur);
      @(negedge pclk);
      chk1(clr, exp_clr(c, e, cur));
    end
    close_out;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    close_out;
  end
endmodule
